// File: pkg/fsc_regs.vh
// constants for the fuse, signature and calibration store
// assumes inclusion by the design files of this block only
`ifndef FSC_REGS_VH
`define FSC_REGS_VH

`define FSC_ACT_ADDR      2'b00
`define FSC_ACT_DATA      2'b01
`define FSC_ACT_CMD       2'b10
`define FSC_ACT_IDLE      2'b11

`define FSC_CMD_ERASE     8'h80
`define FSC_CMD_WR_FUSE   8'h40
`define FSC_CMD_WR_LOCK   8'h20
`define FSC_CMD_RD_SIG    8'h08
`define FSC_CMD_RD_FUSE   8'h04

`define FSC_EXT_RESET     8'hff
`define FSC_HIGH_RESET    8'h99
`define FSC_LOW_RESET     8'h62
`define FSC_LOCK_RESET    8'hff
`define FSC_EXT_UNUSED    8'hf0

`define FSC_SIG_ADDR_0    8'h00
`define FSC_SIG_ADDR_1    8'h01
`define FSC_SIG_ADDR_2    8'h02
`define FSC_SIG_UNUSED    8'hff
`define FSC_SIG_PAGE      8'h00

`define FSC_HB_DEBUG      7
`define FSC_HB_SCAN       6
`define FSC_HB_SERIAL     5
`define FSC_HB_WDOG       4
`define FSC_HB_EEPROM_PRESERVE     3
`define FSC_HB_RSTVEC     0
`define FSC_LB_DIV8       7
`define FSC_LB_CLOCK_OUTPUT_ENABLE      6
`define FSC_LOCK_LB1      0
`define FSC_HB_SERIAL_MASK 8'h20
`define FSC_HB_BOOT_HI    2
`define FSC_HB_BOOT_LO    1
`define FSC_EB_BOD_HI     3
`define FSC_EB_BOD_LO     1
`define FSC_LB_SUT_HI     5
`define FSC_LB_SUT_LO     4
`define FSC_LB_CKS_HI     3
`define FSC_LB_CKS_LO     0

`define FSC_CMD_RESET     8'h00
`define FSC_ADDR_RESET    8'h00
`define FSC_DATA_RESET    8'hff
`define FSC_DOUT_RESET    8'h00
`define FSC_CALIB_RESET   8'h00

`define FSC_BUSY_NS       1000
`define FSC_CLK_MHZ       250

`endif

// File: src/fsc_sig_rom.v
// signature and calibration read-only store, registered read data
// assumes addr/sel stable one cycle before data is used
`timescale 1ns/1ns
`default_nettype none
`include "fsc_regs.vh"

module fsc_sig_rom #(
	parameter [7:0] SIG0  = 8'h5a, // arbitrary identity value
	parameter [7:0] SIG1  = 8'h5b, // arbitrary identity value
	parameter [7:0] SIG2  = 8'h5c, // arbitrary identity value
	parameter [7:0] CALIB = 8'h80  // plain default calibration
) (
	input  wire       clk,   // system clock
	input  wire       rst,   // async reset
	input  wire [7:0] addr,  // signature address
	input  wire       hi,    // high byte select
	output reg  [7:0] rdata  // registered data
);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= `FSC_SIG_UNUSED;
		end else if (hi) begin
			rdata <= (addr == `FSC_SIG_ADDR_0) ? CALIB : `FSC_SIG_UNUSED;
		end else begin
			case (addr)
				`FSC_SIG_ADDR_0: rdata <= SIG0;
				`FSC_SIG_ADDR_1: rdata <= SIG1;
				`FSC_SIG_ADDR_2: rdata <= SIG2;
				default:         rdata <= `FSC_SIG_UNUSED;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: src/fsc_busy_timer.v
// busy interval timer for nonvolatile write operations
// assumes start is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
`include "fsc_regs.vh"

module fsc_busy_timer #(
	parameter CYCLES = 250 // busy length in clocks
) (
	input  wire clk,   // system clock
	input  wire rst,   // async reset
	input  wire start, // begin busy
	output wire busy,  // operation in progress
	output reg  done   // one-cycle end pulse
);
	reg [15:0] cnt_r;

	assign busy = (cnt_r != 16'h0000);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 16'h0000;
			done  <= 1'b0;
		end else begin
			done <= (cnt_r == 16'h0001);
			if (start)
				cnt_r <= CYCLES[15:0];
			else if (busy)
				cnt_r <= cnt_r - 16'h0001;
		end
	end
endmodule
`default_nettype wire

// File: src/fsc_top.v
// fuse store with parallel programming port, signature space and calibration load
// assumes programmer pins already synchronous to clk; prog_mode from entry logic
`timescale 1ns/1ns
`default_nettype none
`include "fsc_regs.vh"

module fsc_top #(
	parameter [7:0] SIG0  = 8'h5a, // arbitrary identity value
	parameter [7:0] SIG1  = 8'h5b, // arbitrary identity value
	parameter [7:0] SIG2  = 8'h5c, // arbitrary identity value
	parameter [7:0] CALIB = 8'h80  // calibration default
) (
	input  wire       clk,                   // system clock
	input  wire       rst,                   // async reset, power-up/reset
	input  wire       prog_mode,             // parallel programming mode active
	input  wire       crystal_input_strobe,  // programming action strobe
	input  wire       action_select_hi,      // action select high
	input  wire       action_select_lo,      // action select low
	input  wire       byte_select_first,     // byte select 1
	input  wire       byte_select_second,    // byte select 2
	input  wire       write_strobe_n,        // write pulse, active low
	input  wire       output_enable_n,       // output enable, active low
	input  wire [7:0] data_in,               // data bus in
	output reg  [7:0] data_out,              // data bus out
	output wire       data_oe,               // data bus drive enable
	output wire       ready_busy_out,        // 1 ready, 0 busy
	input  wire       serial_access,         // request comes from serial port
	input  wire       sys_clk_in,            // system clock to forward
	input  wire       sleep_req,             // core requests sleep
	output reg  [7:0] osc_calibration_reg,   // calibration register
	output wire       onchip_debug_enable,   // active high
	output wire       boundary_scan_enable,  // active high
	output wire       serial_download_enable,// active high
	output wire       watchdog_forced_on,    // active high
	output wire       eeprom_preserve,       // active high
	output wire [1:0] boot_size,             // raw fuse bits
	output wire       reset_vector_select,   // raw fuse bit
	output wire [2:0] brownout_level,        // raw fuse bits
	output wire       clock_divide_eight,    // active high
	output wire       clock_output_enable,   // active high
	output wire       clock_out_pin,         // port pin clock out
	output wire [1:0] startup_time,          // raw fuse bits
	output wire [3:0] clock_source,          // raw fuse bits
	output wire       sleep_clock_keep,      // clocks stay on in sleep
	output wire [7:0] lock_bits              // lock byte contents
);
	localparam BUSY_CYC = (`FSC_BUSY_NS * `FSC_CLK_MHZ + 999) / 1000;

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_BUSY = 2'b01;

	// nonvolatile cells and latched copies
	reg [7:0] nv_ext_r, nv_high_r, nv_low_r, nv_lock_r;
	reg [7:0] lat_ext_r, lat_high_r, lat_low_r;
	reg [7:0] cmd_r, addr_lo_r, addr_hi_r, data_lo_r;
	reg       xs_d_r, wr_d_r, oe_d_r, pm_d_r;
	reg [1:0] st_r, st_nxt;
	reg       eeprom_preserve_r;
	reg       boot_r;

	wire xs_rise = crystal_input_strobe & ~xs_d_r;
	wire wr_fall = ~write_strobe_n & wr_d_r;
	wire oe_fall = ~output_enable_n & oe_d_r;
	wire [1:0] act = {action_select_hi, action_select_lo};
	wire locked  = ~nv_lock_r[`FSC_LOCK_LB1];
	wire done;
	wire [7:0] sig_data;
	// signature space is a single page: any other high address reads as unused
	wire [7:0] sig_addr = (addr_hi_r == `FSC_SIG_PAGE) ? addr_lo_r : `FSC_SIG_UNUSED;

	function [7:0] fuse_pick;
		input       bs1;
		input       bs2;
		input [7:0] e;
		input [7:0] h;
		input [7:0] l;
		begin
			if (bs2)
				fuse_pick = e;
			else if (bs1)
				fuse_pick = h;
			else
				fuse_pick = l;
		end
	endfunction

	// fuse write only accepted when idle and lock bit one unprogrammed; lock and erase writes need only idle
	wire start_wr = wr_fall & prog_mode & (st_r == ST_IDLE);
	wire fuse_wr  = start_wr & (cmd_r == `FSC_CMD_WR_FUSE) & ~locked;
	wire lock_wr  = start_wr & (cmd_r == `FSC_CMD_WR_LOCK);
	wire erase_wr = start_wr & (cmd_r == `FSC_CMD_ERASE);

	fsc_busy_timer #(.CYCLES(BUSY_CYC)) u_busy (
		.clk   (clk),
		.rst   (rst),
		.start (fuse_wr | lock_wr | erase_wr),
		.busy  (),
		.done  (done)
	);

	fsc_sig_rom #(.SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2), .CALIB(CALIB)) u_sig (
		.clk   (clk),
		.rst   (rst),
		.addr  (sig_addr),
		.hi    (byte_select_first),
		.rdata (sig_data)
	);

	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: if (fuse_wr | lock_wr | erase_wr) st_nxt = ST_BUSY;
			ST_BUSY: if (done) st_nxt = ST_IDLE;
			default: st_nxt = ST_IDLE;
		endcase
	end

	assign ready_busy_out = (st_r == ST_IDLE);

	// strobe edge detectors and action decoding
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			xs_d_r    <= 1'b0;
			wr_d_r    <= 1'b1;
			oe_d_r    <= 1'b1;
			cmd_r     <= `FSC_CMD_RESET;
			addr_lo_r <= `FSC_ADDR_RESET;
			addr_hi_r <= `FSC_ADDR_RESET;
			data_lo_r <= `FSC_DATA_RESET;
			st_r      <= ST_IDLE;
		end else begin
			xs_d_r <= crystal_input_strobe;
			wr_d_r <= write_strobe_n;
			oe_d_r <= output_enable_n;
			st_r   <= st_nxt;
			if (xs_rise & prog_mode) begin
				case (act)
					`FSC_ACT_ADDR: begin
						if (byte_select_first)
							addr_hi_r <= data_in;
						else
							addr_lo_r <= data_in;
					end
					`FSC_ACT_DATA: data_lo_r <= data_in;
					`FSC_ACT_CMD:  cmd_r     <= data_in;
					default:       ;
				endcase
			end
		end
	end

	// nonvolatile cells: reset value models an unprogrammed part; erase resets only the lock byte
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			nv_ext_r  <= `FSC_EXT_RESET;
			nv_high_r <= `FSC_HIGH_RESET;
			nv_low_r  <= `FSC_LOW_RESET;
			nv_lock_r <= `FSC_LOCK_RESET;
		end else begin
			if (fuse_wr) begin
				if (byte_select_second)
					nv_ext_r <= data_lo_r | `FSC_EXT_UNUSED;
				else if (byte_select_first) begin
					nv_high_r <= data_lo_r;
					if (serial_access)
						nv_high_r[`FSC_HB_SERIAL] <= nv_high_r[`FSC_HB_SERIAL];
				end else
					nv_low_r <= data_lo_r;
			end
			if (lock_wr)
				nv_lock_r <= nv_lock_r & data_lo_r;
			if (erase_wr)
				nv_lock_r <= `FSC_LOCK_RESET;
		end
	end

	// latch on power-up and on entry to programming mode; eeprom_preserve live
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			lat_ext_r  <= `FSC_EXT_RESET;
			lat_high_r <= `FSC_HIGH_RESET;
			lat_low_r  <= `FSC_LOW_RESET;
			pm_d_r     <= 1'b0;
			eeprom_preserve_r   <= 1'b1;
			boot_r     <= 1'b1;
		end else begin
			pm_d_r   <= prog_mode;
			boot_r   <= 1'b0;
			eeprom_preserve_r <= nv_high_r[`FSC_HB_EEPROM_PRESERVE];
			if (boot_r | (prog_mode & ~pm_d_r)) begin
				lat_ext_r  <= nv_ext_r;
				lat_high_r <= nv_high_r;
				lat_low_r  <= nv_low_r;
			end
		end
	end

	// calibration copied while reset is released, every reset
	always @(posedge clk or posedge rst) begin
		if (rst)
			osc_calibration_reg <= `FSC_CALIB_RESET;
		else if (boot_r)
			osc_calibration_reg <= CALIB;
	end

	// read data register; oe asserts drive
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out <= `FSC_DOUT_RESET;
		end else if (oe_fall & prog_mode) begin
			case (cmd_r)
				`FSC_CMD_RD_SIG:  data_out <= sig_data;
				`FSC_CMD_RD_FUSE: begin
					if (byte_select_second & byte_select_first)
						data_out <= nv_lock_r;
					// serial side never sees the serial-enable fuse: shows unprogrammed
					else if (byte_select_first & serial_access)
						data_out <= nv_high_r | `FSC_HB_SERIAL_MASK;
					else
						data_out <= fuse_pick(byte_select_first, byte_select_second,
							nv_ext_r, nv_high_r, nv_low_r);
				end
				default: data_out <= `FSC_SIG_UNUSED;
			endcase
		end
	end

	assign data_oe = prog_mode & ~output_enable_n;

	// configuration outputs: zero in a fuse means feature on for the flags; boot_size, reset_vector_select and the other fields are raw
	assign onchip_debug_enable    = ~lat_high_r[`FSC_HB_DEBUG];
	assign boundary_scan_enable   = ~lat_high_r[`FSC_HB_SCAN];
	assign serial_download_enable = ~lat_high_r[`FSC_HB_SERIAL];
	assign watchdog_forced_on     = ~lat_high_r[`FSC_HB_WDOG];
	assign eeprom_preserve        = ~eeprom_preserve_r;
	assign boot_size              = lat_high_r[`FSC_HB_BOOT_HI:`FSC_HB_BOOT_LO];
	assign reset_vector_select    = lat_high_r[`FSC_HB_RSTVEC];
	assign brownout_level         = lat_ext_r[`FSC_EB_BOD_HI:`FSC_EB_BOD_LO];
	assign clock_divide_eight     = ~lat_low_r[`FSC_LB_DIV8];
	assign clock_output_enable    = ~lat_low_r[`FSC_LB_CLOCK_OUTPUT_ENABLE];
	assign startup_time           = lat_low_r[`FSC_LB_SUT_HI:`FSC_LB_SUT_LO];
	assign clock_source           = lat_low_r[`FSC_LB_CKS_HI:`FSC_LB_CKS_LO];
	// gated forward of the system clock; glitch safety is the pad's job
	assign clock_out_pin          = clock_output_enable & sys_clk_in;
	assign sleep_clock_keep       = onchip_debug_enable & sleep_req;
	assign lock_bits              = nv_lock_r;
endmodule
`default_nettype wire

// File: test/fsc_props.sv
// assertions on the fuse store's top-level ports
// assumes bound into fsc_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module fsc_props #(
	parameter [7:0] CALIB = 8'h80 // calibration
) (
	input wire logic       clk, // clock
	input wire logic       rst, // reset
	input wire logic       prog_mode, // mode
	input wire logic       write_strobe_n, // write
	input wire logic       output_enable_n, // read
	input wire logic [7:0] data_out, // data
	input wire logic       data_oe, // drive
	input wire logic       ready_busy_out, // ready
	input wire logic       sys_clk_in, // clock in
	input wire logic       sleep_req, // sleep
	input wire logic [7:0] osc_calibration_reg, // calib
	input wire logic       onchip_debug_enable, // debug
	input wire logic       clock_output_enable, // clock_output_enable
	input wire logic       clock_out_pin, // pin
	input wire logic       sleep_clock_keep, // keep
	input wire logic [2:0] brownout_level // level
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_OE_DRIVE: assert property (data_oe == (prog_mode && !output_enable_n))
		else $error("bus drive wrong");
	AST_CLK_OUT: assert property (clock_out_pin == (sys_clk_in && clock_output_enable))
		else $error("clock out wrong");
	AST_SLEEP_CLK: assert property (sleep_clock_keep == (onchip_debug_enable && sleep_req))
		else $error("sleep clock wrong");
	AST_BUSY_CAUSE: assert property ($fell(ready_busy_out) |-> !$past(write_strobe_n))
		else $error("busy without write");
	AST_BUSY_LEN: assert property ($fell(ready_busy_out) |-> ##[245:256] $rose(ready_busy_out))
		else $error("busy length wrong");
	AST_CALIB_LOAD: assert property ($fell(rst) |-> ##[0:3] osc_calibration_reg == CALIB)
		else $error("calibration not loaded");
	AST_CFG_HOLD: assert property ($stable(prog_mode) [*3] |->
		$stable({onchip_debug_enable, clock_output_enable, brownout_level}))
		else $error("config moved");
	AST_RD_HOLD: assert property (output_enable_n && $past(output_enable_n) |-> $stable(data_out))
		else $error("read data moved");
	CVR_WRITE: cover property ($fell(ready_busy_out));
	CVR_READ: cover property ($fell(output_enable_n) && prog_mode);
	CVR_LATCH: cover property ($rose(prog_mode));
endmodule
bind fsc_top fsc_props #(.CALIB(CALIB)) fsc_props_i (.*);
`default_nettype wire

// File: test/fsc_prog_model.sv
// programmer model driving the parallel programming pins
// assumes the store samples pins on rising clk
`timescale 1ns/1ns
`default_nettype none
module fsc_prog_model #(
	parameter PW = 63 // clocks per pulse
) (
	input  wire logic       clk, // clock
	input  wire logic       ready_busy_out, // ready
	input  wire logic [7:0] data_out, // read data
	output var  logic       crystal_input_strobe, // strobe
	output var  logic       action_select_hi, // action 1
	output var  logic       action_select_lo, // action 0
	output var  logic       byte_select_first, // select 1
	output var  logic       byte_select_second, // select 2
	output var  logic       write_strobe_n, // write
	output var  logic       output_enable_n, // read
	output var  logic [7:0] data_in // data
);
	initial begin
		{crystal_input_strobe, action_select_hi, action_select_lo} = 3'h3;
		{byte_select_first, byte_select_second, write_strobe_n, output_enable_n} = 4'h3;
		data_in = 8'h00;
	end
	task automatic pulse(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		{action_select_hi, action_select_lo} <= a;
		{byte_select_second, byte_select_first} <= 2'h0;
		data_in <= d;
		@(posedge clk);
		crystal_input_strobe <= 1'b1;
		repeat (PW) @(posedge clk);
		crystal_input_strobe <= 1'b0;
		// bus released: show the inverse, not a stale copy
		data_in <= ~d;
		@(posedge clk);
	endtask
	task automatic rd(input logic [1:0] bs, output logic [7:0] q);
		@(posedge clk);
		{byte_select_second, byte_select_first} <= bs;
		repeat (2) @(posedge clk);
		output_enable_n <= 1'b0;
		repeat (PW) @(posedge clk);
		q = data_out;
		output_enable_n <= 1'b1;
	endtask
	task automatic wr(input logic [1:0] bs, output logic busy);
		busy = 1'b0;
		@(posedge clk);
		{byte_select_second, byte_select_first} <= bs;
		@(posedge clk);
		write_strobe_n <= 1'b0;
		for (int i = 0; i < 400; i++) begin
			@(posedge clk);
			if (i == PW)
				write_strobe_n <= 1'b1;
			busy = busy | !ready_busy_out;
			if (i > PW && ready_busy_out)
				break;
		end
	endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// bench: programmer-model sequences against the fuse store
// assumes design, model and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
	localparam [7:0] SIG0 = 8'h3c, SIG1 = 8'h4d, SIG2 = 8'h6e; // arbitrary values
	localparam [7:0] CALIB = 8'ha7;
	logic [7:0] sig [4] = '{SIG0, SIG1, SIG2, 8'hff};
	logic       clk, rst, prog_mode, serial_access, sys_clk_in, sleep_req, busy;
	logic [7:0] data_in, data_out, osc_calibration_reg, lock_bits, q;
	logic [3:0] clock_source;
	logic [2:0] brownout_level;
	logic [1:0] boot_size, startup_time;
	logic       crystal_input_strobe, action_select_hi, action_select_lo, byte_select_first;
	logic       byte_select_second, write_strobe_n, output_enable_n, data_oe, ready_busy_out;
	logic       onchip_debug_enable, boundary_scan_enable, serial_download_enable, watchdog_forced_on;
	logic       eeprom_preserve, reset_vector_select, clock_divide_eight, clock_output_enable;
	logic       clock_out_pin, sleep_clock_keep;
	int         num_errors = 0, total_checks = 0;
	fsc_top #(.SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2), .CALIB(CALIB)) fsc_top_i (.*);
	fsc_prog_model fsc_prog_model_i (.*);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic pl(input logic [1:0] a, input logic [7:0] d);
		fsc_prog_model_i.pulse(a, d);
	endtask
	task automatic rchk(input logic [1:0] bs, input logic [7:0] exp);
		fsc_prog_model_i.rd(bs, q);
		check(q, exp);
	endtask
	task automatic wrx(input logic [1:0] bs, input logic [7:0] d, input logic [7:0] c);
		pl(2'h2, c);
		pl(2'h1, d);
		fsc_prog_model_i.wr(bs, busy);
		if (ready_busy_out !== 1'b1) begin
			check(ready_busy_out, 8'h01);
			conclude();
		end
	endtask
	task automatic rall(input logic [7:0] l, input logic [7:0] h, input logic [7:0] e);
		pl(2'h2, 8'h04);
		rchk(2'h0, l);
		rchk(2'h1, h);
		rchk(2'h2, e);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
		sys_clk_in <= ~sys_clk_in;
	initial begin
		{rst, prog_mode, serial_access, sys_clk_in, sleep_req} = 5'h11;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check(osc_calibration_reg, CALIB);
		check({onchip_debug_enable, boundary_scan_enable, serial_download_enable, watchdog_forced_on}, 8'h06);
		check({eeprom_preserve, boot_size, reset_vector_select, brownout_level}, 8'h0f);
		check({clock_divide_eight, clock_output_enable, startup_time, clock_source}, 8'ha2);
		prog_mode <= 1'b1;
		pl(2'h2, 8'h08);
		for (int i = 0; i < 4; i++) begin
			pl(2'h0, i[7:0]);
			rchk(2'h0, sig[i]);
		end
		pl(2'h0, 8'h00);
		rchk(2'h1, CALIB);
		rall(8'h62, 8'h99, 8'hff);
		wrx(2'h1, 8'h11, 8'h40);
		check({busy, eeprom_preserve, onchip_debug_enable}, 8'h06);
		serial_access <= 1'b1;
		wrx(2'h1, 8'h31, 8'h40);
		pl(2'h2, 8'h04);
		rchk(2'h1, 8'h31);
		serial_access <= 1'b0;
		wrx(2'h2, 8'h00, 8'h40);
		wrx(2'h0, 8'hbf, 8'h40);
		wrx(2'h0, 8'h00, 8'h80);
		rall(8'hbf, 8'h11, 8'hf0);
		prog_mode <= 1'b0;
		repeat (4) @(posedge clk);
		prog_mode <= 1'b1;
		repeat (4) @(posedge clk);
		check({onchip_debug_enable, boundary_scan_enable, serial_download_enable, watchdog_forced_on}, 8'h0e);
		check({sleep_clock_keep, boot_size, reset_vector_select, brownout_level}, 8'h48);
		check({clock_divide_eight, clock_output_enable, startup_time, clock_source}, 8'h7f);
		wrx(2'h0, 8'hfe, 8'h20);
		pl(2'h2, 8'h04);
		rchk(2'h3, 8'hfe);
		check(lock_bits, 8'hfe);
		wrx(2'h1, 8'hff, 8'h40);
		check(busy, 8'h00);
		rall(8'hbf, 8'h11, 8'hf0);
		pl(2'h2, 8'h08);
		pl(2'h0, 8'h02);
		rchk(2'h0, SIG2);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		check(osc_calibration_reg, 8'h00);
		check(data_out, 8'h00);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check(osc_calibration_reg, CALIB);
		check({onchip_debug_enable, boundary_scan_enable, serial_download_enable, watchdog_forced_on}, 8'h06);
		conclude();
	end
endmodule
`default_nettype wire
